// [src/audio_timer_pkg.sv]
/*
  Shared constants for the four-channel sound timer block: register
  offsets on the write port, bit positions in the shared and per-channel
  control registers, reset values and the underflow pipeline depth.
  Assumes every user compiles this package before the design files.
*/
`default_nettype none

package audio_timer_pkg;

  // channel and register geometry
  localparam int unsigned CHANNEL_COUNT   = 4;
  localparam int unsigned COUNTER_WIDTH   = 8;
  localparam int unsigned ADDRESS_WIDTH   = 4;
  localparam int unsigned VOLUME_WIDTH    = 4;

  typedef logic [COUNTER_WIDTH-1:0] byte_type;
  typedef logic [ADDRESS_WIDTH-1:0] address_type;
  typedef logic [VOLUME_WIDTH-1:0]  volume_type;

  // write-port offsets: divisor and waveform control interleave per channel
  localparam address_type CHANNEL1_DIVISOR_OFFSET    = 4'h0;
  localparam address_type CHANNEL1_WAVEFORM_OFFSET   = 4'h1;
  localparam address_type CHANNEL_STRIDE             = 4'h2;
  localparam address_type SHARED_SOUND_CONTROL_OFFSET = 4'h8;

  // reset values of the write-only registers and of the counters
  localparam byte_type DIVISOR_RESET          = 8'h00;
  localparam byte_type WAVEFORM_CONTROL_RESET = 8'h00;
  localparam byte_type SHARED_CONTROL_RESET   = 8'h00;
  localparam byte_type COUNTER_RESET          = 8'h00;

  // shared_sound_control fields
  localparam int unsigned BASE_CLOCK_SELECT_BIT = 0;
  localparam int unsigned LINK_34_BIT           = 3;
  localparam int unsigned LINK_12_BIT           = 4;
  localparam int unsigned FAST_CLOCK_3_BIT      = 5;
  localparam int unsigned FAST_CLOCK_1_BIT      = 6;

  // channel_waveform_control fields
  localparam int unsigned VOLUME_LSB          = 0;
  localparam int unsigned VOLUME_ONLY_BIT     = 4;
  localparam int unsigned SQUARE_SELECT_BIT   = 5;
  localparam int unsigned POLY4_SELECT_BIT    = 6;
  localparam int unsigned UNGATED_CLOCK_BIT   = 7;

  // cycles from a counter borrow to the timer pulse
  localparam int unsigned UNDERFLOW_DELAY = 3;
  typedef logic [1:0] stage_type;
  localparam stage_type STAGE_IDLE  = 2'h0;
  // the registered pulse supplies the last of the three cycles
  localparam stage_type STAGE_START = 2'(UNDERFLOW_DELAY - 1);
  localparam stage_type STAGE_FIRE  = 2'h1;

endpackage

`default_nettype wire

// [src/wave_stage_if.sv]
/*
  Carrier between the timer core and one channel's waveform stage:
  timer pulse, control byte, shared noise bits and the resulting level.
  Assumes both ends run on the one machine clock.
*/
`default_nettype none

interface wave_stage_if;
  import audio_timer_pkg::*;

  logic       timer_pulse;
  byte_type   control;
  logic       poly4_bit;
  logic       poly5_bit;
  logic       poly17_bit;
  volume_type level;

  modport stage (
    input  timer_pulse,
    input  control,
    input  poly4_bit,
    input  poly5_bit,
    input  poly17_bit,
    output level
  );

  modport feed (
    output timer_pulse,
    output control,
    output poly4_bit,
    output poly5_bit,
    output poly17_bit,
    input  level
  );
endinterface

`default_nettype wire

// [src/audio_wave_stage.sv]
/*
  Output waveform stage of one sound channel: poly-5 gating of timer
  pulses, square toggle or noise sampling, volume-only override and
  volume gating. Assumes the noise bits come from the shared generators.
*/
`default_nettype none

module audio_wave_stage (
  input  wire logic  clock,
  input  wire logic  reset_n,
  wave_stage_if.stage wave
);
  import audio_timer_pkg::*;

  logic accepted;
  logic digital_out;
  logic next_digital_out;

  always_comb begin
    // poly-5 masks pulses unless the ungated bit is set
    accepted = wave.timer_pulse &&
               (wave.control[UNGATED_CLOCK_BIT] || wave.poly5_bit);
    next_digital_out = digital_out;
    if (accepted) begin
      if (wave.control[SQUARE_SELECT_BIT]) begin
        next_digital_out = !digital_out;
      end else if (wave.control[POLY4_SELECT_BIT]) begin
        next_digital_out = wave.poly4_bit;
      end else begin
        next_digital_out = wave.poly17_bit;
      end
    end
  end

  // keeps running in volume-only mode so hidden state stays live
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      digital_out <= 1'b0;
    end else begin
      digital_out <= next_digital_out;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wave.level <= '0;
    end else if (wave.control[VOLUME_ONLY_BIT] || digital_out) begin
      wave.level <= wave.control[VOLUME_LSB +: VOLUME_WIDTH];
    end else begin
      wave.level <= '0;
    end
  end

endmodule

`default_nettype wire

// [src/audio_timer_channels.sv]
/*
  Four-channel sound timer block: write-only divisor, waveform control
  and shared control registers, four 8-bit countdown timers with base,
  fast and linked clocking, and one waveform stage per channel.
  Assumes tick enables and noise bits arrive as single-cycle, clock-
  synchronous signals from a separate clock and noise generator, and
  that the clock input is the machine clock of the block.
*/
`default_nettype none

module audio_timer_channels #(
  parameter int unsigned CHANNELS      = audio_timer_pkg::CHANNEL_COUNT,
  parameter int unsigned COUNTER_BITS  = audio_timer_pkg::COUNTER_WIDTH
) (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire logic                         write_enable,
  input  wire audio_timer_pkg::address_type write_address,
  input  wire audio_timer_pkg::byte_type    write_data,
  input  wire logic                         tick_15k,
  input  wire logic                         tick_64k,
  input  wire logic                         poly4_bit,
  input  wire logic                         poly5_bit,
  input  wire logic                         poly17_bit,
  output var  logic [3:0]                   timer_pulse,
  output var  audio_timer_pkg::volume_type  channel_level [4]
);
  import audio_timer_pkg::*;

  // the channel wiring below is written for exactly four 8-bit timers
  if (CHANNELS != CHANNEL_COUNT) begin : check_channels
    $error("audio_timer_channels supports exactly four channels");
  end
  if (COUNTER_BITS != COUNTER_WIDTH) begin : check_width
    $error("audio_timer_channels supports only 8-bit counters");
  end

  // write-only register file
  byte_type channel_divisor_regs [4];
  byte_type channel_waveform_regs [4];
  byte_type shared_sound_control;

  // timer core state
  byte_type  counter [4];
  stage_type underflow_stage [4];

  // per-channel steering decoded from the shared control register
  logic       base_tick;
  logic [3:0] tick_enable;
  logic [3:0] low_linked;
  logic [3:0] reload;
  logic [3:0] counting;
  logic [3:0] borrow;

  logic link_12;
  logic link_34;

  assign link_12 = shared_sound_control[LINK_12_BIT];
  assign link_34 = shared_sound_control[LINK_34_BIT];

  // register writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shared_sound_control <= SHARED_CONTROL_RESET;
    end else if (write_enable && write_address == SHARED_SOUND_CONTROL_OFFSET) begin
      shared_sound_control <= write_data;
    end
  end

  for (genvar reg_index = 0; reg_index < 4; reg_index++) begin : gen_registers
    localparam address_type DIVISOR_ADDRESS =
      4'(CHANNEL1_DIVISOR_OFFSET + CHANNEL_STRIDE * reg_index);
    localparam address_type WAVEFORM_ADDRESS =
      4'(CHANNEL1_WAVEFORM_OFFSET + CHANNEL_STRIDE * reg_index);

    // held aside until the counter reloads, never loaded directly
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        channel_divisor_regs[reg_index] <= DIVISOR_RESET;
      end else if (write_enable && write_address == DIVISOR_ADDRESS) begin
        channel_divisor_regs[reg_index] <= write_data;
      end
    end

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        channel_waveform_regs[reg_index] <= WAVEFORM_CONTROL_RESET;
      end else if (write_enable && write_address == WAVEFORM_ADDRESS) begin
        channel_waveform_regs[reg_index] <= write_data;
      end
    end
  end

  // clock routing and linking, decided ahead of any waveform setting
  always_comb begin
    // only one base tick can ever be live
    base_tick = shared_sound_control[BASE_CLOCK_SELECT_BIT] ? tick_15k : tick_64k;

    tick_enable[0] = shared_sound_control[FAST_CLOCK_1_BIT] ? 1'b1 : base_tick;
    tick_enable[2] = shared_sound_control[FAST_CLOCK_3_BIT] ? 1'b1 : base_tick;
    // chained high timers count only the low timer's pulses
    tick_enable[1] = link_12 ? timer_pulse[0] : base_tick;
    tick_enable[3] = link_34 ? timer_pulse[2] : base_tick;

    low_linked = {1'b0, link_34, 1'b0, link_12};

    // a chained low reloads only with its high partner
    reload[0] = link_12 ? timer_pulse[1] : timer_pulse[0];
    reload[1] = timer_pulse[1];
    reload[2] = link_34 ? timer_pulse[3] : timer_pulse[2];
    reload[3] = timer_pulse[3];
  end

  for (genvar ch = 0; ch < 4; ch++) begin : gen_timers
    // an unlinked counter sits still while its underflow drains;
    // a chained low keeps wrapping so it fires every 256 ticks
    assign counting[ch] = tick_enable[ch] &&
                          (underflow_stage[ch] == STAGE_IDLE || low_linked[ch]);
    assign borrow[ch]   = counting[ch] && counter[ch] == COUNTER_RESET;

    // reload wins over counting; the divisor is sampled only here
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        counter[ch] <= COUNTER_RESET;
      end else if (reload[ch]) begin
        counter[ch] <= channel_divisor_regs[ch];
      end else if (counting[ch]) begin
        counter[ch] <= counter[ch] - 8'h01;
      end
    end

    // staged-counter latency between the borrow and the pulse
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        underflow_stage[ch] <= STAGE_IDLE;
      end else if (borrow[ch]) begin
        underflow_stage[ch] <= STAGE_START;
      end else if (underflow_stage[ch] != STAGE_IDLE) begin
        underflow_stage[ch] <= underflow_stage[ch] - 2'h1;
      end
    end

    // the joint reload starts no stage in the low timer, so no extra pulse
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        timer_pulse[ch] <= 1'b0;
      end else begin
        timer_pulse[ch] <= underflow_stage[ch] == STAGE_FIRE;
      end
    end
  end

  // waveform stages see the timer pulses but feed nothing back
  for (genvar ch = 0; ch < 4; ch++) begin : gen_waves
    wave_stage_if wave ();

    assign wave.timer_pulse = timer_pulse[ch];
    assign wave.control     = channel_waveform_regs[ch];
    // one shared generator set feeds every channel
    assign wave.poly4_bit   = poly4_bit;
    assign wave.poly5_bit   = poly5_bit;
    assign wave.poly17_bit  = poly17_bit;
    assign channel_level[ch] = wave.level;

    audio_wave_stage audio_wave_stage_i (
      .clock   (clock),
      .reset_n (reset_n),
      .wave    (wave.stage)
    );
  end

endmodule

`default_nettype wire

// [bench/audio_tick_source.sv]
/*
  Model of the clock and noise generator feeding the timer block:
  base tick enables every 28 and 114 cycles, noise levels from an LFSR.
  Assumes it shares the machine clock and reset with the block.
*/
`default_nettype none

module audio_tick_source (
  input  wire logic clock,
  input  wire logic reset_n,
  output var  logic tick_15k,
  output var  logic tick_64k,
  output var  logic poly4_bit,
  output var  logic poly5_bit,
  output var  logic poly17_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]  c15;
  logic [4:0]  c64;
  logic [16:0] lfsr;

  // driven on the falling edge, like the rest of the stimulus
  always @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      c15 <= 7'h05;
      c64 <= 5'h00;
      lfsr <= 17'h1abcd;
    end else begin
      c15 <= (c15 == 7'h71) ? 7'h00 : c15 + 7'h01;
      c64 <= (c64 == 5'h1b) ? 5'h00 : c64 + 5'h01;
      lfsr <= {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    end
  end

  // one-cycle enables, phases apart so a wrong tick choice shows
  assign tick_15k   = (c15 == 7'h71);
  assign tick_64k   = (c64 == 5'h1b);
  assign poly4_bit  = lfsr[3];
  assign poly5_bit  = lfsr[7];
  assign poly17_bit = lfsr[16];
endmodule

`default_nettype wire

// [bench/audio_timer_channels_properties.sv]
/*
  Port-level checker for the sound timer block, bound into its top.
  Assumes register offsets and field positions of audio_timer_pkg.
*/
`default_nettype none

module audio_timer_channels_checker #(
  parameter int unsigned CHANNELS     = 4,
  parameter int unsigned COUNTER_BITS = 8
) (
  input wire logic                         clock,
  input wire logic                         reset_n,
  input wire logic                         write_enable,
  input wire audio_timer_pkg::address_type write_address,
  input wire audio_timer_pkg::byte_type    write_data,
  input wire logic                         tick_15k,
  input wire logic                         tick_64k,
  input wire logic                         poly4_bit,
  input wire logic                         poly5_bit,
  input wire logic                         poly17_bit,
  input wire logic [3:0]                   timer_pulse,
  input wire audio_timer_pkg::volume_type  channel_level [4]
);
  timeunit 1ns;
  timeprecision 1ps;
  import audio_timer_pkg::*;
  byte_type   div [4];
  byte_type   ctl [4];
  byte_type   shr;
  logic [9:0] age;
  logic [8:0] gap1;
  logic [8:0] gap3;
  logic       steady;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      div <= '{default: 8'h00};
      ctl <= '{default: 8'h00};
      shr <= 8'h00;
    end else if (write_enable && write_address == SHARED_SOUND_CONTROL_OFFSET) begin
      shr <= write_data;
    end else if (write_enable && write_address < 4'h8) begin
      if (write_address[0]) ctl[write_address[2:1]] <= write_data;
      else div[write_address[2:1]] <= write_data;
    end
  end

  // settle time covers a reload using the old divisor
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) age <= 10'h000;
    else if (write_enable) age <= 10'h000;
    else if (age != 10'h3ff) age <= age + 10'h001;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) gap1 <= 9'h000;
    else gap1 <= timer_pulse[0] ? 9'h001 : gap1 + 9'h001;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) gap3 <= 9'h000;
    else gap3 <= timer_pulse[2] ? 9'h001 : gap3 + 9'h001;
  end

  assign steady = age > 10'h258;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence low_silent;
    !timer_pulse[0] [*3];
  endsequence

  AST_FAST1_PERIOD: assert property (steady && shr[FAST_CLOCK_1_BIT] && !shr[LINK_12_BIT]
    && timer_pulse[0] |-> gap1 == 9'(div[0]) + 9'h004) else $error("timer 1 period");
  AST_FAST3_PERIOD: assert property (steady && shr[FAST_CLOCK_3_BIT] && !shr[LINK_34_BIT]
    && timer_pulse[2] |-> gap3 == 9'(div[2]) + 9'h004) else $error("timer 3 period");
  AST_BASE_ALIGN: assert property (steady && !shr[LINK_12_BIT] && timer_pulse[1]
    |-> (shr[0] ? $past(tick_15k, 3) : $past(tick_64k, 3))) else $error("tick alignment");
  AST_LINK_HIGH: assert property (steady && shr[LINK_12_BIT] && timer_pulse[1]
    |-> $past(timer_pulse[0], 3)) else $error("linked high delay");
  AST_LINK_LOW: assert property (steady && shr[LINK_12_BIT] && timer_pulse[1]
    |=> low_silent) else $error("extra low pulse on joint reload");

  for (genvar i = 0; i < 4; i++) begin : g_ch
    AST_ONE_CYCLE: assert property (timer_pulse[i] |=> !timer_pulse[i])
      else $error("pulse longer than one cycle");
    AST_LEVEL_VALUE: assert property (steady |-> channel_level[i] == 4'h0
      || channel_level[i] == ctl[i][3:0]) else $error("level not volume or zero");
    AST_VOL_ONLY: assert property (steady && ctl[i][VOLUME_ONLY_BIT]
      |-> channel_level[i] == ctl[i][3:0]) else $error("volume-only level");
    AST_LEVEL_CAUSE: assert property (steady && !ctl[i][VOLUME_ONLY_BIT]
      && $changed(channel_level[i]) |-> $past(timer_pulse[i], 2)) else $error("level moved");
  end
endmodule

bind audio_timer_channels audio_timer_channels_checker #(
  .CHANNELS(CHANNELS),
  .COUNTER_BITS(COUNTER_BITS)
) audio_timer_channels_checker_i (.clock, .reset_n, .write_enable, .write_address,
  .write_data, .tick_15k, .tick_64k, .poly4_bit, .poly5_bit, .poly17_bit,
  .timer_pulse, .channel_level);

`default_nettype wire

// [bench/tb_audio_timer_channels.sv]
/*
  Self-checking bench for the sound timer block: period notes are queued
  by the driver and matched against measured pulse spacing by a monitor.
  Assumes the tick source model and the bound checker.
*/
`default_nettype none

module tb_audio_timer_channels;
  timeunit 1ns;
  timeprecision 1ps;
  import audio_timer_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        write_enable = 1'b0;
  address_type write_address = 4'h0;
  byte_type    write_data = 8'h00;
  logic        tick_15k, tick_64k, poly4_bit, poly5_bit, poly17_bit;
  logic [3:0]  timer_pulse;
  volume_type  channel_level [4];
  logic [15:0] notes [$];
  logic [3:0]  modes [7] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'ha, 4'hc, 4'h1};
  logic [1:0]  watch = 2'h0;
  int          last = -1;
  int          cyc = 0;
  int          errors = 0;
  int          n_tests = 0;
  int          seed = 38;
  byte_type    n_lo;
  volume_type  lv;

  audio_timer_channels audio_timer_channels_i (.clock, .reset_n, .write_enable,
    .write_address, .write_data, .tick_15k, .tick_64k, .poly4_bit, .poly5_bit,
    .poly17_bit, .timer_pulse, .channel_level);
  audio_tick_source audio_tick_source_i (.clock, .reset_n, .tick_15k, .tick_64k,
    .poly4_bit, .poly5_bit, .poly17_bit);

  always #10 clock = ~clock;
  always @(posedge clock) cyc++;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // outputs read mid-cycle, long after the rising edge settled them
  always @(negedge clock) begin
    if (timer_pulse[watch] === 1'b1) begin
      if (last >= 0 && notes.size() > 0) check(16'(cyc - last), notes.pop_front());
      last = cyc;
    end
  end

  task automatic wr(input address_type a, input byte_type d);
    @(negedge clock);
    write_enable = 1'b1;
    write_address = a;
    write_data = d;
    @(negedge clock);
    write_enable = 1'b0;
  endtask

  task automatic measure(input logic [1:0] ch, input logic [15:0] per);
    int k;
    repeat (700) @(negedge clock);
    watch = ch;
    last = -1;
    repeat (3) notes.push_back(per);
    for (k = 0; k < 4000 && notes.size() > 0; k++) @(negedge clock);
    if (notes.size() > 0) begin
      errors++;
      final_report();
    end
    $display("test done on timer %0d", ch + 1);
  endtask

  task automatic wait_pulse;
    int k;
    for (k = 0; k < 2000 && timer_pulse[0] !== 1'b1; k++) @(negedge clock);
    if (k == 2000) begin
      errors++;
      final_report();
    end
    repeat (3) @(negedge clock);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    for (int m = 0; m < 7; m++) begin
      n_lo = (m == 0) ? 8'hff : (m == 1) ? 8'h00 : 8'($random(seed));
      wr(4'h0, n_lo);
      wr(4'h1, {modes[m], 4'h5});
      wr(4'h8, 8'h40);
      measure(2'h0, 16'(n_lo) + 16'h0004);
    end
    wr(4'h1, 8'ha7);
    wait_pulse();
    lv = channel_level[0];
    wait_pulse();
    check(16'(lv ^ channel_level[0]), 16'h0007);
    wr(4'h7, 8'h1b);
    repeat (4) @(negedge clock);
    check(16'(channel_level[3]), 16'h000b);
    wr(4'h4, 8'h00);
    wr(4'h8, 8'h20);
    wr(4'hf, 8'h1f);
    measure(2'h2, 16'h0004);
    wr(4'h2, 8'h02);
    wr(4'h8, 8'h00);
    measure(2'h1, 16'd84);
    wr(4'h6, 8'h01);
    wr(4'h8, 8'h01);
    measure(2'h3, 16'd228);
    wr(4'h0, 8'h05);
    wr(4'h2, 8'h01);
    wr(4'h8, 8'h50);
    repeat (1000) @(negedge clock);
    measure(2'h1, 16'd268);
    wr(4'h4, 8'h03);
    wr(4'h8, 8'h28);
    measure(2'h3, 16'd266);
    final_report();
  end
endmodule

`default_nettype wire
